// ---- design/rcf_pkg_fifo.sv ----
// Package of framer constants and the output character FIFO
`default_nettype none
package rcf_pkg;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_NINE = 8'h39;
  localparam logic [7:0] CHAR_UA = 8'h41;
  localparam logic [7:0] CHAR_UF = 8'h46;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] STR_SEP = 8'h00;
  localparam logic [3:0] NIB_TEN = 4'ha;
  localparam logic [3:0] NIB_LETTER_OFS = 4'h9;
  localparam logic [7:0] RSP_NEG = 8'h00;
  localparam logic [7:0] RSP_FINAL = 8'h01;
  localparam logic [7:0] RSP_INTERIM = 8'h02;
  localparam logic [2:0] NEG_LEN = 3'h1;
  localparam logic [15:0] MAX_PAY = 16'h0004;
  localparam logic [15:0] LEN_NONE = 16'h0000;
  localparam logic [3:0] POS_FIRST = 4'h1;
  localparam logic [3:0] POS_STEP = 4'h1;
  localparam logic [3:0] POS_SEQ_END = 4'h1;
  localparam logic [3:0] POS_CMD_END = 4'h3;
  localparam logic [3:0] POS_SEL_END = 4'h5;
  localparam logic [3:0] POS_IDX_END = 4'h7;
  localparam logic [3:0] POS_LEN_END = 4'hb;
  localparam logic [3:0] POS_CHK_END = 4'h3;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [3:0] STR_FIRST = 4'h1;
  localparam logic [3:0] STR_STEP = 4'h1;
  localparam logic [3:0] STR_MAX = 4'h4;
  localparam logic [3:0] TXB_SEQ = 4'h0;
  localparam logic [3:0] TXB_CODE = 4'h1;
  localparam logic [3:0] TXB_LENHI = 4'h2;
  localparam logic [3:0] TXB_LENLO = 4'h3;
  localparam logic [3:0] TXB_PAY = 4'h4;
  localparam logic [3:0] BYTE_STEP = 4'h1;
  localparam logic [7:0] LEN_HI_ZERO = 8'h00;
  localparam logic [15:0] CRC_POLY_DEF = 16'h1021;
  localparam logic [15:0] CRC_INIT_DEF = 16'h0000;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [5:0] {
    RX_IDLE = 6'h01,
    RX_HDR = 6'h02,
    RX_PAY = 6'h04,
    RX_CHK = 6'h08,
    RX_END = 6'h10,
    RX_SKIP = 6'h20
  } rcf_rx_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_BODY = 3'h2,
    TX_CR = 3'h4
  } rcf_tx_t;

  function automatic logic [15:0] rcf_crc_byte(input logic [15:0] crc, input logic [7:0] b,
                                                input logic [15:0] poly);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ poly) : (c << 1);
    end
    return c;
  endfunction : rcf_crc_byte

  function automatic logic rcf_is_hex(input logic [7:0] ch);
    return (ch >= CHAR_ZERO && ch <= CHAR_NINE) || (ch >= CHAR_UA && ch <= CHAR_UF);
  endfunction : rcf_is_hex

  function automatic logic [3:0] rcf_hex_val(input logic [7:0] ch);
    return (ch <= CHAR_NINE) ? ch[3:0] : ch[3:0] + NIB_LETTER_OFS;
  endfunction : rcf_hex_val

  function automatic logic [7:0] rcf_hex_char(input logic [3:0] nib);
    return (nib < NIB_TEN) ? (CHAR_ZERO | {4'h0, nib}) : (CHAR_UA + {4'h0, nib - NIB_TEN});
  endfunction : rcf_hex_char
endpackage : rcf_pkg

module rcf_fifo #(
  parameter int WIDTH = rcf_pkg::FIFO_WIDTH,
  parameter int DEPTH = rcf_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  import rcf_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PTR_STEP = AW'(1);
  localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } rcf_fifo_st_t;

  rcf_fifo_st_t s;
  rcf_fifo_st_t next_s;
  logic push;
  logic pop;

  assign inReady = s.cnt != FULL;
  assign outValid = s.cnt != '0;
  assign outData = s.mem[s.rd];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr] = inData;
      next_s.wr = s.wr + PTR_STEP;
    end
    if (pop)
    begin
      next_s.rd = s.rd + PTR_STEP;
    end
    case ({push, pop})
      2'b10: next_s.cnt = s.cnt + CNT_ONE;
      2'b01: next_s.cnt = s.cnt - CNT_ONE;
      default: next_s.cnt = s.cnt;
    endcase
    if (!resetn)
    begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    s <= next_s;
  end
endmodule : rcf_fifo
`default_nettype wire

// ---- design/rcf_framer.sv ----
// Remote command framer: request parser, duplicate filter and reply builder
`default_nettype none
// Rules of the remote command link
// RL1: Payload bytes travel as two upper-case hex characters, 0-9 and A-F only.
// RL2: A carriage return ends every request frame.
// RL3: Characters before a request's first character after a CR void the request.
// RL4: Malformed requests are dropped without any reply.
// RL5: Host resends the same request when no reply comes within a short time.
// RL6: Multi-byte values go most significant byte first.
// RL7: Request is seq, command, selector, index, four-char length, payload, check, CR.
// RL8: Host advances sequence per new request, keeps it on retries.
// RL9: Every reply echoes the request's sequence number.
// RL10: Repeated sequence number replays the stored last reply, no new command.
// RL11: Host zeroes selector and index when a command does not use them.
// RL12: Length field counts payload bytes, zero when no payload.
// RL13: Check field is a 16-bit CRC over all characters before it.
// RL14: CRC over the whole intact reply including its check leaves zero.
// RL15: Reply is seq, code, length, payload, check, then an always-sent CR.
// RL16: Reply payload holds reason or contents; empty replies carry zero length.
// RL17: A lone integer takes one to four bytes, two to eight characters.
// RL18: Integers inside structures keep their fixed width.
// RL19: Strings are split by a zero byte, none after the last.
// RL20: Received strings are checked for count, length and control characters; the block checks only count and control characters.
// RL21: Reply codes: zero negative, one final positive, two interim positive.
// RL22: A negative reply carries exactly one reason byte.
// RL23: CRC polynomial and initial value are parameters with a common default.
// RL24: Frames overflowing the receive buffer are dropped until the next CR.
// RL25: Payload character count must match the length field.
module rcf_framer #(
  parameter logic [15:0] CRC_POLY = rcf_pkg::CRC_POLY_DEF,
  parameter logic [15:0] CRC_INIT = rcf_pkg::CRC_INIT_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic cmdValid,
  output logic [7:0] cmdSeq,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdSelector,
  output logic [7:0] cmdIndex,
  output logic [15:0] cmdLen,
  output logic [31:0] cmdData,
  output logic [3:0] cmdStrCount,
  output logic cmdStrBad,
  input wire logic rspValid,
  output logic rspReady,
  input wire logic [7:0] rspCode,
  input wire logic [2:0] rspLen,
  input wire logic [31:0] rspData
);
  import rcf_pkg::*;

  typedef struct packed {
    rcf_rx_t rxSt;
    logic [3:0] pos;
    logic [15:0] acc;
    logic [7:0] seq;
    logic [7:0] cmd;
    logic [7:0] sel;
    logic [7:0] idx;
    logic [15:0] len;
    logic [3:0] payCnt;
    logic [31:0] pay;
    logic [15:0] crc;
    logic [3:0] strCnt;
    logic ctrl;
    logic [7:0] lastSeq;
    logic haveLast;
    logic [7:0] execSeq;
    logic cmdValid;
    logic pendReplay;
    rcf_tx_t txSt;
    logic [3:0] txByte;
    logic txHalf;
    logic [7:0] txSeq;
    logic [7:0] txCode;
    logic [2:0] txLen;
    logic [31:0] txData;
    logic [15:0] txCrc;
    logic haveReply;
  } rcf_state_t;

  rcf_state_t s;
  rcf_state_t next_s;
  logic hexOk;
  logic isCr;
  logic [3:0] nib;
  logic [15:0] accN;
  logic [15:0] crcN;
  logic [15:0] residue;
  logic [3:0] twoLen;
  logic [3:0] payEnd;
  logic [3:0] payIdx;
  logic [7:0] payByte;
  logic [7:0] txVal;
  logic [7:0] txChar;
  logic fifoInValid;
  logic fifoReady;
  logic [7:0] fifoInData;

  assign hexOk = rcf_is_hex(rxData); // RL1
  assign isCr = rxData == CHAR_CR; // RL2
  assign nib = rcf_hex_val(rxData);
  assign accN = {s.acc[11:0], nib}; // RL6
  assign crcN = rcf_crc_byte(s.crc, rxData, CRC_POLY); // RL13
  assign residue = rcf_crc_byte(rcf_crc_byte(s.crc, accN[15:8], CRC_POLY), accN[7:0], CRC_POLY);
  assign twoLen = {s.len[2:0], 1'b0}; // RL12

  // Reply character generator
  assign payEnd = TXB_PAY + {1'b0, s.txLen};
  assign payIdx = payEnd - BYTE_STEP - s.txByte;
  assign payByte = 8'(s.txData >> {payIdx[1:0], 3'b000}); // RL6
  assign txVal = (s.txByte == TXB_SEQ) ? s.txSeq :
                 (s.txByte == TXB_CODE) ? s.txCode :
                 (s.txByte == TXB_LENHI) ? LEN_HI_ZERO :
                 (s.txByte == TXB_LENLO) ? {5'h00, s.txLen} :
                 (s.txByte < payEnd) ? payByte :
                 (s.txByte == payEnd) ? s.txCrc[15:8] : s.txCrc[7:0]; // RL15
  assign txChar = rcf_hex_char(s.txHalf ? txVal[3:0] : txVal[7:4]); // RL1
  assign fifoInValid = (s.txSt == TX_BODY) || (s.txSt == TX_CR);
  assign fifoInData = (s.txSt == TX_CR) ? CHAR_CR : txChar; // RL15
  assign rspReady = (s.txSt == TX_IDLE) && !s.pendReplay;

  assign cmdValid = s.cmdValid;
  assign cmdSeq = s.seq;
  assign cmdCode = s.cmd;
  assign cmdSelector = s.sel;
  assign cmdIndex = s.idx;
  assign cmdLen = s.len;
  assign cmdData = s.pay;
  assign cmdStrCount = s.strCnt;
  assign cmdStrBad = s.ctrl || (s.strCnt > STR_MAX); // RL20

  always_comb
  begin
    next_s = s;
    next_s.cmdValid = 1'b0;
    // Transmit side
    case (s.txSt)
      TX_IDLE:
      begin
        if (s.pendReplay)
        begin
          next_s.pendReplay = 1'b0;
          next_s.txSt = TX_BODY;
          next_s.txByte = TXB_SEQ;
          next_s.txHalf = 1'b0;
          next_s.txCrc = CRC_INIT;
        end
        else if (rspValid)
        begin
          next_s.txSeq = s.execSeq; // RL9
          next_s.txCode = rspCode; // RL21
          next_s.txLen = (rspCode == RSP_NEG) ? NEG_LEN : rspLen; // RL22
          next_s.txData = rspData; // RL16
          next_s.haveReply = 1'b1;
          next_s.txSt = TX_BODY;
          next_s.txByte = TXB_SEQ;
          next_s.txHalf = 1'b0;
          next_s.txCrc = CRC_INIT; // RL23
        end
      end
      TX_BODY:
      begin
        if (fifoReady)
        begin
          if (s.txByte < payEnd)
          begin
            next_s.txCrc = rcf_crc_byte(s.txCrc, txChar, CRC_POLY); // RL14
          end
          next_s.txHalf = !s.txHalf;
          if (s.txHalf)
          begin
            next_s.txByte = s.txByte + BYTE_STEP;
          end
          if (s.txHalf && s.txByte == payEnd + BYTE_STEP)
          begin
            next_s.txSt = TX_CR; // RL15
          end
        end
      end
      TX_CR:
      begin
        if (fifoReady)
        begin
          next_s.txSt = TX_IDLE;
        end
      end
      default: next_s.txSt = TX_IDLE;
    endcase
    // Receive side
    if (rxValid)
    begin
      case (s.rxSt)
        RX_IDLE:
        begin
          if (isCr)
          begin
            next_s.rxSt = RX_IDLE;
          end
          else if (hexOk)
          begin
            next_s.rxSt = RX_HDR; // RL7
            next_s.pos = POS_FIRST;
            next_s.acc = {12'h000, nib};
            next_s.crc = rcf_crc_byte(CRC_INIT, rxData, CRC_POLY); // RL23
            next_s.pay = '0;
            next_s.payCnt = '0;
            next_s.strCnt = STR_FIRST; // RL19
            next_s.ctrl = 1'b0;
          end
          else
          begin
            next_s.rxSt = RX_SKIP; // RL4
          end
        end
        RX_HDR:
        begin
          if (isCr)
          begin
            next_s.rxSt = RX_IDLE; // RL4
          end
          else if (!hexOk)
          begin
            next_s.rxSt = RX_SKIP; // RL1
          end
          else
          begin
            next_s.acc = accN;
            next_s.crc = crcN;
            next_s.pos = s.pos + POS_STEP;
            case (s.pos) // RL7
              POS_SEQ_END: next_s.seq = accN[7:0];
              POS_CMD_END: next_s.cmd = accN[7:0];
              POS_SEL_END: next_s.sel = accN[7:0];
              POS_IDX_END: next_s.idx = accN[7:0];
              POS_LEN_END:
              begin
                next_s.len = accN; // RL18
                next_s.pos = '0;
                if (accN > MAX_PAY)
                begin
                  next_s.rxSt = RX_SKIP; // RL24
                end
                else
                begin
                  next_s.rxSt = (accN == LEN_NONE) ? RX_CHK : RX_PAY; // RL12
                end
              end
              default: next_s.pos = s.pos + POS_STEP;
            endcase
          end
        end
        RX_PAY:
        begin
          if (isCr)
          begin
            next_s.rxSt = RX_IDLE; // RL25
          end
          else if (!hexOk)
          begin
            next_s.rxSt = RX_SKIP;
          end
          else
          begin
            next_s.acc = accN;
            next_s.crc = crcN;
            next_s.pay = {s.pay[27:0], nib}; // RL17
            next_s.payCnt = s.payCnt + CNT_STEP;
            if (s.payCnt[0])
            begin
              if (accN[7:0] == STR_SEP)
              begin
                next_s.strCnt = s.strCnt + STR_STEP; // RL19
              end
              else if (accN[7:0] < CHAR_SPACE)
              begin
                next_s.ctrl = 1'b1; // RL20
              end
            end
            if (next_s.payCnt == twoLen)
            begin
              next_s.rxSt = RX_CHK; // RL25
              next_s.pos = '0;
            end
          end
        end
        RX_CHK:
        begin
          if (isCr)
          begin
            next_s.rxSt = RX_IDLE;
          end
          else if (!hexOk)
          begin
            next_s.rxSt = RX_SKIP;
          end
          else
          begin
            next_s.acc = accN;
            next_s.pos = s.pos + POS_STEP;
            if (s.pos == POS_CHK_END)
            begin
              next_s.rxSt = (residue == CRC_GOOD) ? RX_END : RX_SKIP; // RL13
            end
          end
        end
        RX_END:
        begin
          if (isCr)
          begin
            next_s.rxSt = RX_IDLE;
            next_s.lastSeq = s.seq;
            next_s.haveLast = 1'b1;
            if (s.haveLast && s.seq == s.lastSeq)
            begin
              next_s.pendReplay = s.haveReply; // RL10
            end
            else
            begin
              next_s.cmdValid = 1'b1;
              next_s.execSeq = s.seq; // RL9
            end
          end
          else
          begin
            next_s.rxSt = RX_SKIP; // RL25
          end
        end
        RX_SKIP:
        begin
          if (isCr)
          begin
            next_s.rxSt = RX_IDLE; // RL3
          end
        end
        default: next_s.rxSt = RX_IDLE;
      endcase
    end
    if (!resetn)
    begin
      next_s = '0;
      next_s.rxSt = RX_IDLE;
      next_s.txSt = TX_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

  rcf_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(fifoInValid),
    .inReady(fifoReady),
    .inData(fifoInData),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_nak_len: // RL22
  assert property ((rspValid && rspReady && rspCode == RSP_NEG) |=> (s.txLen == NEG_LEN))
    else $error("Negative reply length is not one");

  a_seq_echo: // RL9
  assert property ((rspValid && rspReady) |=>
                   (fifoInValid && s.txSeq == s.execSeq &&
                    fifoInData == rcf_hex_char(s.txSeq[7:4])))
    else $error("Reply does not open with the echoed sequence");

  a_hex_only: // RL1
  assert property ((s.txSt == TX_BODY) |-> rcf_is_hex(fifoInData))
    else $error("Reply body character is not upper-case hex");

  a_cr_close: // RL15
  assert property ((s.txSt == TX_CR && fifoReady) |-> (fifoInData == CHAR_CR) ##1
                   (s.txSt == TX_IDLE))
    else $error("Reply not closed by carriage return");

  a_silent_drop: // RL4
  assert property (cmdValid |-> $past(rxValid && isCr && s.rxSt == RX_END))
    else $error("Command issued without a complete valid frame");

  a_dup_replay: // RL10
  assert property ((rxValid && isCr && s.rxSt == RX_END && s.haveLast &&
                    s.seq == s.lastSeq) |=> (!cmdValid && s.pendReplay == s.haveReply))
    else $error("Repeated sequence executed again");

  a_skip_line: // RL3
  assert property ((rxValid && s.rxSt == RX_SKIP && !isCr) |=> (s.rxSt == RX_SKIP))
    else $error("Discard mode left before carriage return");

  a_pay_bound: // RL24
  assert property ((s.rxSt == RX_PAY) |-> (s.len <= MAX_PAY && s.len != LEN_NONE))
    else $error("Payload longer than buffer accepted");

  a_crc_gate: // RL13
  assert property ((rxValid && s.rxSt == RX_CHK && s.pos == POS_CHK_END && hexOk &&
                    !isCr && residue != CRC_GOOD) |=> (s.rxSt == RX_SKIP))
    else $error("Bad check value accepted");
endmodule : rcf_framer
`default_nettype wire

// ---- verif/rcf_host_model.sv ----
// Host model of the remote command link: request sender and reply collector
`default_nettype none
module rcf_host_model #(
  parameter logic [15:0] POLY = 16'h1021
) (
  input wire logic clk,
  input wire logic stall,
  output var logic [7:0] rxData,
  output var logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output var logic txReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bq[$];
  logic [7:0] rxq[$];
  logic [7:0] expq[$];
  initial
  begin
    rxData = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  // Collects reply characters, slowed down on request
  always @(posedge clk)
  begin
    txReady <= !stall;
    if (txValid && txReady)
      rxq.push_back(txData);
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hx
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? ((r << 1) ^ POLY) : (r << 1);
    return r;
  endfunction : crcStep
  function void put8(input logic [7:0] b);
    bq.push_back(hx(b[7:4]));
    bq.push_back(hx(b[3:0]));
  endfunction : put8
  // Appends the check value over all characters so far, then the line end
  function void addCheck();
    logic [15:0] c;
    c = 16'h0000;
    foreach (bq[i])
      c = crcStep(c, bq[i]);
    put8(c[15:8]);
    put8(c[7:0]);
    bq.push_back(8'h0d);
  endfunction : addCheck
  // Builds the characters of the expected reply
  function void mkReply(input logic [7:0] seq, code, input logic [2:0] len, input logic [31:0] d);
    bq.delete();
    put8(seq);
    put8(code);
    put8(8'h00);
    put8({5'h00, len});
    for (int i = int'(len) - 1; i >= 0; i--)
      put8(d[8*i+:8]);
    addCheck();
    expq = bq;
  endfunction : mkReply
  // Sends one request; bad selects a deliberate flaw, 0 for none
  task automatic sendReq(input logic [7:0] seq, cmd, sel, idx, input logic [15:0] len,
                         input logic [39:0] d, input int bad);
    int n;
    n = (bad == 3) ? int'(len) - 1 : int'(len);
    bq.delete();
    if (bad == 2)
      bq.push_back(8'h47);
    put8(seq);
    put8(cmd);
    put8(sel);
    put8(idx);
    put8(len[15:8]);
    put8(len[7:0]);
    for (int i = n - 1; i >= 0; i--)
      put8(d[8*i+:8]);
    addCheck();
    // Another hex digit, so only the check value is wrong
    if (bad == 1)
      bq[bq.size()-2] = (bq[bq.size()-2] == 8'h30) ? 8'h31 : 8'h30;
    if (bad == 4)
      bq[3] = bq[3] | 8'h20;
    foreach (bq[i])
    begin
      @(posedge clk);
      rxData <= bq[i];
      rxValid <= 1'b1;
      @(posedge clk);
      rxData <= ~bq[i];
      rxValid <= 1'b0;
    end
  endtask : sendReq
endmodule : rcf_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench of the remote command framer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [7:0] seq, cmd, sel, idx;
    logic [15:0] len;
    logic [39:0] data;
    logic [4:0] str;
    logic [7:0] rCode;
    logic [2:0] rLen;
    logic [31:0] rData;
    logic slow;
  } rcf_row_t;
  // Request, expected {string count, bad}, offered reply, stalled host
  rcf_row_t rows[6] = '{
    '{8'h01, 8'h10, 8'h00, 8'h00, 16'h0000, 40'h0, 5'h02, 8'h01, 3'h0, 32'h0, 1'b0},
    '{8'h02, 8'h21, 8'h03, 8'h07, 16'h0002, 40'h1b9c, 5'h03, 8'h01, 3'h4, 32'hdeadbeef, 1'b1},
    '{8'h03, 8'h22, 8'h00, 8'h00, 16'h0003, 40'h410042, 5'h04, 8'h02, 3'h2, 32'ha5, 1'b0},
    '{8'h04, 8'h23, 8'h01, 8'h00, 16'h0004, 40'h41014243, 5'h03, 8'h00, 3'h3, 32'h7, 1'b0},
    '{8'h05, 8'h24, 8'hff, 8'hff, 16'h0001, 40'h0, 5'h04, 8'h01, 3'h1, 32'h5a, 1'b0},
    '{8'h06, 8'h25, 8'h00, 8'h00, 16'h0004, 40'h0, 5'h0b, 8'h01, 3'h4, 32'h01020304, 1'b0}};
  logic clk = 1'b0;
  logic resetn, rspValid, stall, rxValid, txValid, txReady, cmdValid, rspReady, cmdStrBad;
  logic [7:0] rspCode, rxData, txData, cmdSeq, cmdCode, cmdSelector, cmdIndex;
  logic [2:0] rspLen;
  logic [31:0] rspData, cmdData, capHdr, capData;
  logic [15:0] cmdLen, capLen;
  logic [3:0] cmdStrCount;
  logic [4:0] capStr;
  int err_count = 0;
  int n_tests = 0;
  int cmdCnt = 0;
  always #12.5 clk = ~clk;
  rcf_framer i_dut (.clk, .resetn, .rxData, .rxValid, .txData, .txValid, .txReady, .cmdValid,
    .cmdSeq, .cmdCode, .cmdSelector, .cmdIndex, .cmdLen, .cmdData, .cmdStrCount, .cmdStrBad,
    .rspValid, .rspReady, .rspCode, .rspLen, .rspData);
  rcf_host_model i_host (.clk, .stall, .rxData, .rxValid, .txData, .txValid, .txReady);
  always @(posedge clk)
    if (cmdValid === 1'b1)
    begin
      cmdCnt <= cmdCnt + 1;
      capHdr <= {cmdSeq, cmdCode, cmdSelector, cmdIndex};
      capLen <= cmdLen;
      capData <= cmdData;
      capStr <= {cmdStrCount, cmdStrBad};
    end
  task automatic check(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Offers a reply and holds it until the framer takes it
  task automatic offer(input logic [7:0] code, input logic [2:0] len, input logic [31:0] d);
    int k;
    @(posedge clk);
    rspValid <= 1'b1;
    rspCode <= code;
    rspLen <= len;
    rspData <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rspReady !== 1'b1 && k < 400);
    rspValid <= 1'b0;
    rspData <= ~d;
  endtask : offer
  // Waits for a complete reply line and compares it with the expected one
  task automatic waitReply();
    for (int i = 0; i < 600; i++)
    begin
      @(posedge clk);
      if (i_host.rxq.size() > 0 && i_host.rxq[$] == 8'h0d)
        break;
    end
    check(i_host.rxq.size(), i_host.expq.size());
    for (int i = 0; i < i_host.expq.size(); i++)
      check(i_host.rxq[i], i_host.expq[i]);
    i_host.rxq.delete();
  endtask : waitReply
  // Sends a flawed request and expects neither command nor reply
  task automatic dropped(input int bad);
    int n;
    n = cmdCnt;
    i_host.sendReq(8'h07, 8'h2a, 8'h00, 8'h00, (bad == 5) ? 16'h0005 : 16'h0002,
                   40'h1234567890, bad);
    tick(60);
    check(cmdCnt, n);
    check(i_host.rxq.size(), 0);
  endtask : dropped
  initial
  begin
    int n;
    resetn = 1'b0;
    rspValid = 1'b0;
    rspCode = 8'h00;
    rspLen = 3'h0;
    rspData = 32'h0;
    stall = 1'b0;
    tick(16);
    resetn <= 1'b1;
    tick(1);
    check({cmdValid, txValid, rspReady, cmdSeq}, {3'b001, 8'h00});
    foreach (rows[r])
    begin
      i_host.sendReq(rows[r].seq, rows[r].cmd, rows[r].sel, rows[r].idx, rows[r].len,
                     rows[r].data, 0);
      tick(3);
      check(cmdCnt, r + 1);
      check(capHdr, {rows[r].seq, rows[r].cmd, rows[r].sel, rows[r].idx});
      check(capLen, rows[r].len);
      check(capData, rows[r].data[31:0]);
      check(capStr, rows[r].str);
      stall <= rows[r].slow;
      offer(rows[r].rCode, rows[r].rLen, rows[r].rData);
      i_host.mkReply(rows[r].seq, rows[r].rCode,
                     (rows[r].rCode == 8'h00) ? 3'h1 : rows[r].rLen, rows[r].rData);
      if (rows[r].slow)
      begin
        tick(40);
        check(i_host.rxq.size(), 0);
        check({txValid, rspReady}, 2'b10);
        stall <= 1'b0;
      end
      waitReply();
      tick(2);
      check(txValid, 1'b0);
    end
    n = cmdCnt;
    i_host.sendReq(8'h06, 8'h25, 8'h00, 8'h00, 16'h0004, 40'h0, 0);
    i_host.mkReply(8'h06, 8'h01, 3'h4, 32'h01020304);
    waitReply();
    check(cmdCnt, n);
    dropped(1);
    dropped(2);
    dropped(3);
    dropped(4);
    dropped(5);
    i_host.sendReq(8'h07, 8'h2a, 8'h00, 8'h00, 16'h0000, 40'h0, 0);
    tick(3);
    check(cmdCnt, n + 1);
    check(capHdr, 32'h072a0000);
    resetn <= 1'b0;
    tick(16);
    check({cmdValid, txValid, rspReady, cmdSeq}, {3'b001, 8'h00});
    resetn <= 1'b1;
    tick(2);
    check({cmdValid, txValid, rspReady}, 3'b001);
    // Reset forgets the last sequence, so the same number counts as new
    i_host.sendReq(8'h07, 8'h2a, 8'h00, 8'h00, 16'h0000, 40'h0, 0);
    tick(3);
    check(cmdCnt, n + 2);
    check(capHdr, 32'h072a0000);
    test_done();
  end
  initial
  begin
    tick(20000);
    err_count++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
